// >>> verilog/ovr_regs_consts.svh
`ifndef OVR_REGS_CONSTS_SVH
`define OVR_REGS_CONSTS_SVH
// Behaviour
// (RULE_01) bits 7:1 of the spare-lane register each enable link-layer clocks of lane Bn, n 1..7.
// (RULE_02) a spare-lane bit turns its lane on even if the link mode does not need it.
// (RULE_03) spare-serializer bit 0 runs only the lane clocks, 1 also runs serializers to send data.
// (RULE_04) software writes spare-lane and sync-header registers only while the link is disabled.
// (RULE_05) spare lanes take rate and mode from the link mode and the test-pattern setting.
// (RULE_06) a lane on only through the spare register with test pattern 0 or 5 sends a ramp (4).
// (RULE_07) spare enables do not override channel power-down; a spare lane needs its link powered.
// (RULE_08) serializer n is clocked only when lanes 0 to n-1 are all enabled.
// (RULE_09) the sync-header mode governs the 32-bit sync word and acts only in 64b/66b modes.
// (RULE_10) sync-header mode 0 sends CRC-12 (default), 2 sends FEC, 1 and 3 are reserved.
// (RULE_11) no command-channel features: every command field of the sync word is sent as zero.
// (RULE_12) the gain bit selects 0 dB filter gain when 0 and 6.02 dB when 1.
// (RULE_13) software sets the extra gain only when the negative image is filtered out.
// (RULE_14) threshold I, reset 0xf2, sets flag bit 0 on I samples whose level reaches it.
// (RULE_15) threshold Q, reset 0xab, sets flag bit 1 on Q samples whose level reaches it.
// (RULE_16) thresholds are scaled against full scale 256.
// (RULE_17) the top eight magnitude bits compared greater or equal set the flag for that sample only.

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SPARE_LANE_OFS   12'h20b
`define SYNC_HDR_OFS     12'h20f
`define DDC_GAIN_OFS     12'h210
`define OVR_THR_I_OFS    12'h211
`define OVR_THR_Q_OFS    12'h212

// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define SPARE_LANE_RST   8'h00
`define SYNC_HDR_RST     8'h00
`define DDC_GAIN_RST     8'h00
`define OVR_THR_I_RST    8'hf2
`define OVR_THR_Q_RST    8'hab
`define SPARE_SER_BIT    0
`define GAIN_BIT         0
`define SYNC_HDR_CRC     2'h0
`define SYNC_HDR_FEC     2'h2
`define TEST_RAMP        4'h4
`define TEST_OFF         4'h0
`define TEST_ALT         4'h5
`define FULL_SCALE       256

`endif

// >>> verilog/ovr_regs_pkg.sv
package ovr_regs_pkg;
  // lane controls toward the serial link
  typedef struct packed {
    logic [7:0] laneClkEn;
    logic [7:0] serClkEn;
    logic [7:0] rampLane;
  } lane_ctrl_t;

  // sync word control toward the 64b/66b framer
  typedef struct packed {
    logic       active;
    logic       sendFec;
    logic       sendCrc;
    logic [4:0] cmdField;
  } sync_ctrl_t;

  typedef enum logic [1:0] {
    SH_CRC,
    SH_RSV1,
    SH_FEC,
    SH_RSV3
  } sync_mode_t;
endpackage

// >>> verilog/ovr_detect.sv
`timescale 1ns/1ps
`include "ovr_regs_consts.svh"
module ovr_detect import ovr_regs_pkg::*; #(
  parameter int SAMPLE_W = 16
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // sample in
  input  wire logic                sampleValid,
  input  wire logic [SAMPLE_W-1:0] sample,
  input  wire logic [7:0]          threshold,
  // flagged sample out
  output logic                     outValid,
  output logic [SAMPLE_W-1:0]      outSample,
  output logic                     outFlag
);
  initial begin
    if (SAMPLE_W < 9) $error("ovr_detect: SAMPLE_W must be at least 9");
  end

  logic [SAMPLE_W-1:0] mag;
  logic [7:0]          magTop;

  // ----------------------------------------------------------------
  // magnitude and compare
  // ----------------------------------------------------------------
  // two's complement magnitude; most negative saturates to all ones
  always_comb begin
    if (sample[SAMPLE_W-1]) begin
      mag = (sample == {1'b1, {(SAMPLE_W-1){1'b0}}}) ? {SAMPLE_W{1'b1}} : (~sample + 1'b1);
    end else begin
      mag = sample;
    end
    magTop = mag[SAMPLE_W-2 -: 8]; // RULE_16
  end

  // flag rides with its own sample, one cycle later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      outValid  <= 1'b0;
      outSample <= '0;
      outFlag   <= 1'b0;
    end else begin
      outValid <= sampleValid;
      if (sampleValid) begin
        outSample <= sample;
        outFlag   <= (magTop >= threshold); // RULE_17
      end
    end
  end
endmodule

// >>> verilog/ddc_gain.sv
`timescale 1ns/1ps
module ddc_gain #(
  parameter int SAMPLE_W = 16
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // control
  input  wire logic                boost,
  // sample path
  input  wire logic                inValid,
  input  wire logic [SAMPLE_W-1:0] inSample,
  output logic                     outValid,
  output logic [SAMPLE_W-1:0]      outSample
);
  initial begin
    if (SAMPLE_W < 2) $error("ddc_gain: SAMPLE_W too small");
  end

  logic [SAMPLE_W-1:0] doubled;
  logic                ovf;

  // ----------------------------------------------------------------
  // x2 gain with saturation
  // ----------------------------------------------------------------
  // clipping is what the user risks when the image is not filtered
  always_comb begin
    ovf     = inSample[SAMPLE_W-1] ^ inSample[SAMPLE_W-2];
    doubled = {inSample[SAMPLE_W-2:0], 1'b0};
    if (ovf) begin
      doubled = inSample[SAMPLE_W-1] ? {1'b1, {(SAMPLE_W-1){1'b0}}}
                                     : {1'b0, {(SAMPLE_W-1){1'b1}}};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      outValid  <= 1'b0;
      outSample <= '0;
    end else begin
      outValid <= inValid;
      if (inValid) begin
        outSample <= boost ? doubled : inSample; // RULE_12
      end
    end
  end
endmodule

// >>> verilog/link_b_lane_ddc_overrange_regs.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "ovr_regs_consts.svh"
module link_b_lane_ddc_overrange_regs import ovr_regs_pkg::*; #(
  parameter int SAMPLE_W = 16
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // register port
  input  wire logic [11:0]         regAddr,
  input  wire logic [7:0]          regWrData,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic [7:0]               regRdData,
  // link context from other registers
  input  wire logic                serialLinkEnable,
  input  wire logic [7:0]          modeLaneMask,
  input  wire logic                linkModeIs66b,
  input  wire logic [3:0]          linkTestPattern,
  input  wire logic                channelPowerDownB,
  // lane and sync controls
  output lane_ctrl_t               laneCtrl,
  output sync_ctrl_t               syncCtrl,
  output logic                     writeWhileLinkOn,
  // I and Q samples in
  input  wire logic                sampleValid,
  input  wire logic [SAMPLE_W-1:0] sampleI,
  input  wire logic [SAMPLE_W-1:0] sampleQ,
  // flagged samples out
  output logic                     outValid,
  output logic [SAMPLE_W-1:0]      outI,
  output logic [SAMPLE_W-1:0]      outQ,
  output logic [1:0]               outFlags
);
  initial begin
    if (SAMPLE_W < 9) $error("link_b_lane_ddc_overrange_regs: SAMPLE_W must be >= 9");
  end

  logic [7:0] spareLane_reg;
  logic [7:0] syncHdr_reg;
  logic [7:0] ddcGain_reg;
  logic [7:0] thrI_reg;
  logic [7:0] thrQ_reg;
  logic [7:0] rdData_next;
  logic       gIValid;
  logic       gQValid;
  logic       iOutValid;
  logic       qOutValid;
  logic [4:0] wrSel;
  logic [4:0] rdSel;
  logic [SAMPLE_W-1:0] gI;
  logic [SAMPLE_W-1:0] gQ;
  logic [7:0] laneClk;
  logic [7:0] serClk;
  logic [7:0] ramp;
  logic [7:0] prefix;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // one-hot select; write, read and the link-on warning share it
  function automatic logic [4:0] regSel(input logic [11:0] addr);
    logic [4:0] sel;
    sel = 5'h00;
    if (addr == `SPARE_LANE_OFS) begin
      sel[0] = 1'b1;
    end else if (addr == `SYNC_HDR_OFS) begin
      sel[1] = 1'b1;
    end else if (addr == `DDC_GAIN_OFS) begin
      sel[2] = 1'b1;
    end else if (addr == `OVR_THR_I_OFS) begin
      sel[3] = 1'b1;
    end else if (addr == `OVR_THR_Q_OFS) begin
      sel[4] = 1'b1;
    end
    return sel;
  endfunction

  // a write strobe on an unmapped address selects nothing
  assign wrSel = regWr ? regSel(regAddr) : 5'h00;
  assign rdSel = regSel(regAddr);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // reserved bits are kept as written, they read back as stored
  // spare-lane enables; a write while the link runs still lands
  always_ff @(posedge core_clk) begin
    if (rst) begin
      spareLane_reg <= `SPARE_LANE_RST;
    end else if (wrSel[0]) begin
      spareLane_reg <= regWrData;
    end
  end

  // sync-header mode; reserved codes are stored, decoded as neither
  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncHdr_reg <= `SYNC_HDR_RST;
    end else if (wrSel[1]) begin
      syncHdr_reg <= regWrData;
    end
  end

  // gain select; takes effect on the next sample through the stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ddcGain_reg <= `DDC_GAIN_RST;
    end else if (wrSel[2]) begin
      ddcGain_reg <= regWrData;
    end
  end

  // threshold for the I flag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      thrI_reg <= `OVR_THR_I_RST; // RULE_14
    end else if (wrSel[3]) begin
      thrI_reg <= regWrData;
    end
  end

  // threshold for the Q flag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      thrQ_reg <= `OVR_THR_Q_RST; // RULE_15
    end else if (wrSel[4]) begin
      thrQ_reg <= regWrData;
    end
  end

  // sticky warning: write not refused, only reported (software's duty)
  always_ff @(posedge core_clk) begin
    if (rst) begin
      writeWhileLinkOn <= 1'b0;
    end else if (serialLinkEnable && (wrSel[0] || wrSel[1])) begin
      writeWhileLinkOn <= 1'b1; // RULE_04
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // unmapped addresses read zero
  always_comb begin
    if (rdSel[0]) begin
      rdData_next = spareLane_reg;
    end else if (rdSel[1]) begin
      rdData_next = syncHdr_reg;
    end else if (rdSel[2]) begin
      rdData_next = ddcGain_reg;
    end else if (rdSel[3]) begin
      rdData_next = thrI_reg;
    end else if (rdSel[4]) begin
      rdData_next = thrQ_reg;
    end else begin
      rdData_next = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      regRdData <= rdData_next;
    end
  end

  // ----------------------------------------------------------------
  // lane and serializer enables
  // ----------------------------------------------------------------
  // lane 0 follows the mode only; spare bits add lanes 1..7
  always_comb begin
    laneClk = modeLaneMask | {spareLane_reg[7:1], 1'b0}; // RULE_01 RULE_02
    if (channelPowerDownB) begin
      laneClk = 8'h00; // RULE_07
    end
  end

  // serializer n needs every lower lane on as well
  always_comb begin
    prefix[0] = 1'b1;
    for (int n = 1; n < 8; n++) begin
      prefix[n] = prefix[n-1] & laneClk[n-1]; // RULE_08
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gLane
      logic spareOnly;
      assign spareOnly = laneClk[g] & ~modeLaneMask[g];
      // spare-only lanes run serializer only with the spare-serializer bit
      assign serClk[g] = laneClk[g] & prefix[g] &
                         (modeLaneMask[g] | spareLane_reg[`SPARE_SER_BIT]); // RULE_03
      // spare-only lanes replace test 0 or 5 with the octet ramp
      assign ramp[g] = spareOnly & ((linkTestPattern == `TEST_OFF) ||
                                    (linkTestPattern == `TEST_ALT)); // RULE_06
    end
  endgenerate

  // rate and mode stay with the link's own selection; only ramp is forced
  always_ff @(posedge core_clk) begin
    if (rst) begin
      laneCtrl <= '0;
    end else begin
      laneCtrl.laneClkEn <= laneClk;
      laneCtrl.serClkEn  <= serClk;
      laneCtrl.rampLane  <= ramp; // RULE_05
    end
  end

  // ----------------------------------------------------------------
  // sync word control
  // ----------------------------------------------------------------
  // reserved codes send neither signal
  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncCtrl <= '0;
    end else begin
      syncCtrl.active   <= linkModeIs66b; // RULE_09
      syncCtrl.sendCrc  <= linkModeIs66b && (syncHdr_reg[1:0] == `SYNC_HDR_CRC); // RULE_10
      syncCtrl.sendFec  <= linkModeIs66b && (syncHdr_reg[1:0] == `SYNC_HDR_FEC); // RULE_10
      syncCtrl.cmdField <= 5'h00; // RULE_11
    end
  end

  // ----------------------------------------------------------------
  // gain then over-range detect
  // ----------------------------------------------------------------
  ddc_gain #(.SAMPLE_W(SAMPLE_W)) uGainI (
    .core_clk  (core_clk),
    .rst       (rst),
    .boost     (ddcGain_reg[`GAIN_BIT]),
    .inValid   (sampleValid),
    .inSample  (sampleI),
    .outValid  (gIValid),
    .outSample (gI)
  );

  ddc_gain #(.SAMPLE_W(SAMPLE_W)) uGainQ (
    .core_clk  (core_clk),
    .rst       (rst),
    .boost     (ddcGain_reg[`GAIN_BIT]),
    .inValid   (sampleValid),
    .inSample  (sampleQ),
    .outValid  (gQValid),
    .outSample (gQ)
  );

  ovr_detect #(.SAMPLE_W(SAMPLE_W)) uOvrI (
    .core_clk    (core_clk),
    .rst         (rst),
    .sampleValid (gIValid),
    .sample      (gI),
    .threshold   (thrI_reg),
    .outValid    (iOutValid),
    .outSample   (outI),
    .outFlag     (outFlags[0]) // RULE_14
  );

  ovr_detect #(.SAMPLE_W(SAMPLE_W)) uOvrQ (
    .core_clk    (core_clk),
    .rst         (rst),
    .sampleValid (gQValid),
    .sample      (gQ),
    .threshold   (thrQ_reg),
    .outValid    (qOutValid),
    .outSample   (outQ),
    .outFlag     (outFlags[1]) // RULE_15
  );

  // both halves of the pair must agree before the sample leaves
  assign outValid = iOutValid & qOutValid;
endmodule

// >>> bench/link_b_regs_props.sv
`timescale 1ns/1ps
`include "ovr_regs_consts.svh"
module link_b_regs_props import ovr_regs_pkg::*; (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // register port
  input wire logic [11:0] regAddr,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [7:0]  regRdData,
  // link context and controls
  input wire logic        serialLinkEnable,
  input wire logic [7:0]  modeLaneMask,
  input wire logic        linkModeIs66b,
  input wire logic        channelPowerDownB,
  input wire lane_ctrl_t  laneCtrl,
  input wire sync_ctrl_t  syncCtrl,
  input wire logic        writeWhileLinkOn,
  // samples
  input wire logic        sampleValid,
  input wire logic        outValid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] prefixOk;
  logic       mapped;

  // lanes below each serializer all clocked
  always_comb begin
    prefixOk[0] = 1'b1;
    for (int i = 1; i < 8; i++) begin
      prefixOk[i] = prefixOk[i-1] & laneCtrl.laneClkEn[i-1];
    end
  end
  assign mapped = regAddr inside {`SPARE_LANE_OFS, `SYNC_HDR_OFS, `DDC_GAIN_OFS,
                                  `OVR_THR_I_OFS, `OVR_THR_Q_OFS};

  sequence rdUnmapped;
    regRd && !mapped;
  endsequence
  sequence wrLinkOn;
    regWr && serialLinkEnable && regAddr == `SPARE_LANE_OFS;
  endsequence

  a_cmd_zero:      assert property (syncCtrl.cmdField == 5'h00)
    else $error("sync command field not zero");
  a_sync_exclusive: assert property (!(syncCtrl.sendFec && syncCtrl.sendCrc))
    else $error("crc and fec both selected");
  a_sync_needs_66b: assert property ((syncCtrl.sendFec || syncCtrl.sendCrc) |-> syncCtrl.active)
    else $error("sync word mode outside 64b/66b");
  a_sync_active:   assert property (!$past(rst) |-> syncCtrl.active == $past(linkModeIs66b))
    else $error("sync active does not follow link mode");
  a_pd_gates:      assert property (!$past(rst) && $past(channelPowerDownB) |-> laneCtrl == '0)
    else $error("lane running while powered down");
  a_mode_lanes_on: assert property (!$past(rst) && !$past(channelPowerDownB)
                     |-> (laneCtrl.laneClkEn & $past(modeLaneMask)) == $past(modeLaneMask))
    else $error("mode lane not clocked");
  a_ser_prefix:    assert property ((laneCtrl.serClkEn & ~prefixOk) == 8'h00)
    else $error("serializer clocked without lower lanes");
  a_ramp_spare:    assert property (!laneCtrl.rampLane[0] &&
                     (laneCtrl.rampLane & ~laneCtrl.laneClkEn) == 8'h00)
    else $error("ramp on a lane that is not a spare");
  a_sample_delay:  assert property (sampleValid |-> ##2 outValid)
    else $error("flagged sample late");
  a_flag_set:      assert property (wrLinkOn |=> writeWhileLinkOn)
    else $error("write with link on not flagged");
  a_flag_sticky:   assert property (!$past(rst) && $past(writeWhileLinkOn) |-> writeWhileLinkOn)
    else $error("write flag cleared without reset");
  a_rd_unmapped:   assert property (rdUnmapped |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind link_b_lane_ddc_overrange_regs link_b_regs_props i_link_b_regs_props (
  .core_clk, .rst, .regAddr, .regWr, .regRd, .regRdData, .serialLinkEnable, .modeLaneMask,
  .linkModeIs66b, .channelPowerDownB, .laneCtrl, .syncCtrl, .writeWhileLinkOn,
  .sampleValid, .outValid);

// >>> bench/tb.sv
`timescale 1ns/1ps
`include "ovr_regs_consts.svh"
module tb import ovr_regs_pkg::*;;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] regAddr = 12'h000;
  logic [7:0]  regWrData = 8'h00;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        serialLinkEnable = 1'b0;
  logic [7:0]  modeLaneMask = 8'h00;
  logic        linkModeIs66b = 1'b0;
  logic [3:0]  linkTestPattern = 4'h0;
  logic        channelPowerDownB = 1'b0;
  logic        sampleValid = 1'b0;
  logic [15:0] sampleI = 16'h0000;
  logic [15:0] sampleQ = 16'h0000;
  logic [7:0]  regRdData;
  lane_ctrl_t  laneCtrl;
  sync_ctrl_t  syncCtrl;
  logic        writeWhileLinkOn;
  logic        outValid;
  logic [15:0] outI;
  logic [15:0] outQ;
  logic [1:0]  outFlags;
  int          failures = 0;
  int          n_tests = 0;
  logic [11:0] ofs [5] = '{`SPARE_LANE_OFS, `SYNC_HDR_OFS, `DDC_GAIN_OFS, `OVR_THR_I_OFS,
                           `OVR_THR_Q_OFS};
  logic [7:0]  mirror [5] = '{`SPARE_LANE_RST, `SYNC_HDR_RST, `DDC_GAIN_RST, `OVR_THR_I_RST,
                              `OVR_THR_Q_RST};

  // ----------------------------------------
  // clock and design
  // ----------------------------------------
  always #5 core_clk = ~core_clk;
  link_b_lane_ddc_overrange_regs #(.SAMPLE_W(16)) i_link_b_lane_ddc_overrange_regs (
    .core_clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .serialLinkEnable,
    .modeLaneMask, .linkModeIs66b, .linkTestPattern, .channelPowerDownB, .laneCtrl, .syncCtrl,
    .writeWhileLinkOn, .sampleValid, .sampleI, .sampleQ, .outValid, .outI, .outQ, .outFlags);

  // ----------------------------------------
  // expectations and bus cycles
  // ----------------------------------------
  function automatic lane_ctrl_t expLane(logic [7:0] sp, logic [7:0] mk, logic [3:0] tp,
                                         logic pd);
    lane_ctrl_t e;
    logic [7:0] spare;
    logic [7:0] want;
    logic       ok;
    e = '0;
    spare = {sp[7:1], 1'b0};
    want = mk | (sp[0] ? spare : 8'h00);
    ok = 1'b1;
    // power-down wins over every spare enable
    if (!pd) begin
      e.laneClkEn = mk | spare;
      for (int i = 0; i < 8; i++) begin
        e.serClkEn[i] = want[i] & ok;
        ok = ok & e.laneClkEn[i];
      end
      e.rampLane = (tp == 4'h0 || tp == 4'h5) ? spare & ~mk : 8'h00;
    end
    return e;
  endfunction
  function automatic sync_ctrl_t expSync(logic [1:0] m, logic a);
    sync_ctrl_t e;
    e = '0;
    e.active = a;
    e.sendCrc = a && m == 2'h0;
    e.sendFec = a && m == 2'h2;
    return e;
  endfunction
  // {flag, gained sample}; doubling saturates, and so does the magnitude of -full-scale
  function automatic logic [16:0] expSamp(logic [15:0] s, logic g, logic [7:0] t);
    int v;
    int m;
    v = $signed(s) * (g ? 2 : 1);
    v = v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
    m = v < 0 ? -v : v;
    m = m > 32767 ? 32767 : m;
    return {m[14:7] >= t, v[15:0]};
  endfunction
  function automatic logic [15:0] pick(logic [7:0] t, int n);
    logic [15:0] b;
    b = {1'b0, t, 7'h00};
    case (n % 5)
      0: return b;
      1: return -b;
      2: return b - 16'h0001;
      3: return 16'h8000;
      default: return 16'($urandom);
    endcase
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] exp);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(posedge core_clk);
    check("regRdData", regRdData, exp);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int          k;
    int          w;
    logic [7:0]  sp;
    logic [7:0]  mk;
    logic [3:0]  tp;
    logic [15:0] sI;
    logic [15:0] sQ;
    logic [16:0] eI;
    logic [16:0] eQ;
    void'($urandom(64109));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    // reset values, then random write and immediate read back
    for (int i = 0; i < 5; i++) rd(ofs[i], mirror[i]);
    rd(12'h213, 8'h00);
    for (int n = 0; n < 24; n++) begin
      k = $urandom_range(4);
      mirror[k] = 8'($urandom);
      wr(ofs[k], mirror[k]);
      rd(ofs[k], mirror[k]);
    end
    wr(12'h20c, 8'h5a);
    for (int i = 0; i < 5; i++) rd(ofs[i], mirror[i]);
    // lane controls over random masks, test settings and power-down
    for (int n = 0; n < 40; n++) begin
      sp = n < 2 ? 8'hff : 8'($urandom);
      mk = n < 2 ? {7'h00, n[0]} : 8'($urandom);
      tp = n % 3 == 0 ? {1'b0, n[0], 1'b0, n[0]} : 4'($urandom);
      modeLaneMask <= mk;
      linkTestPattern <= tp;
      channelPowerDownB <= n % 7 == 3;
      wr(`SPARE_LANE_OFS, sp);
      repeat (2) @(posedge core_clk);
      check("laneCtrl", laneCtrl, expLane(sp, mk, tp, n % 7 == 3));
    end
    // every sync mode, with and without 64b/66b
    for (int m = 0; m < 8; m++) begin
      linkModeIs66b <= m[2];
      wr(`SYNC_HDR_OFS, {6'($urandom), m[1:0]});
      repeat (2) @(posedge core_clk);
      check("syncCtrl", syncCtrl, expSync(m[1:0], m[2]));
    end
    // samples at the threshold boundaries, both gains
    for (int n = 0; n < 60; n++) begin
      if (n % 30 == 0) begin
        mirror[2] = {7'h00, n >= 30};
        mirror[3] = 8'($urandom);
        mirror[4] = 8'($urandom);
        for (int i = 2; i < 5; i++) begin
          wr(ofs[i], mirror[i]);
          rd(ofs[i], mirror[i]);
        end
      end
      sI = pick(mirror[3], n);
      sQ = pick(mirror[4], n + 2);
      sampleValid <= 1'b1;
      sampleI <= sI;
      sampleQ <= sQ;
      @(posedge core_clk);
      sampleValid <= 1'b0;
      for (w = 0; w < 4 && outValid !== 1'b1; w++) @(posedge core_clk);
      if (w == 4) begin
        failures++;
        break;
      end
      eI = expSamp(sI, mirror[2][0], mirror[3]);
      eQ = expSamp(sQ, mirror[2][0], mirror[4]);
      check("outI", outI, eI[15:0]);
      check("outQ", outQ, eQ[15:0]);
      check("outFlags", outFlags, {eQ[16], eI[16]});
    end
    // write while the link runs, then a second reset
    check("writeWhileLinkOn", writeWhileLinkOn, 32'h0);
    serialLinkEnable <= 1'b1;
    wr(`SPARE_LANE_OFS, 8'h00);
    serialLinkEnable <= 1'b0;
    @(posedge core_clk);
    check("writeWhileLinkOn", writeWhileLinkOn, 32'h1);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    rd(`OVR_THR_I_OFS, `OVR_THR_I_RST);
    check("writeWhileLinkOn", writeWhileLinkOn, 32'h0);
    print_verdict();
  end
endmodule
